// ===== logic/level_watch_regs.sv
/*
  Register bank of the supply level watch: margin select, edge selection,
  interrupt enable, sticky flag, last-sampled status and interrupt request.
  Assumes the brown-out mode and level come from fuse-loaded logic on
  sys_clk, and the analog comparator output is asynchronous.
*/
// The address-and-strobe port was decided locally.
// Contract
// - margin code selects 5, 15, 25 percent
// - threshold follows selected brown-out level
// - edge code 0 triggers on falling supply
// - edge code 1 triggers on rising supply
// - edge code 2 triggers either direction
// - control bit 0 enables watch interrupt
// - matching trigger sets the flag
// - flag sets only with detector enabled, clears any time
// - status reads 1 when supply below
// - request while enabled and flag set
// - watch follows detector mode, sampled too
// - enabling with either-edge sets flag in continuous modes
// - sampled mode triggers only on code 1
`timescale 1ns/10ps
module level_watch_regs
  import level_watch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [1:0] bod_mode,
  input wire logic [BOD_LEVEL_W-1:0] brownout_threshold_select,
  input wire logic bod_sample_tick,
  input wire logic cmp_below,
  output logic [THRESH_W-1:0] watch_threshold,
  output logic watch_enable,
  output logic watch_irq
);

  ////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic [1:0] margin_q;
  logic [1:0] margin_d;
  logic [1:0] edge_q;
  logic [1:0] edge_d;
  logic irq_en_q;
  logic irq_en_d;
  logic flag_q;
  logic flag_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [THRESH_W-1:0] thresh_q;
  logic watch_en_q;
  logic irq_q;
  logic below_q;

  wire sel_margin = (reg_addr == OFS_MARGIN_CTRL);
  wire sel_ctrl = (reg_addr == OFS_IRQ_CTRL);
  wire sel_flags = (reg_addr == OFS_IRQ_FLAGS);
  wire sel_status = (reg_addr == OFS_STATUS);
  wire wr_margin = reg_wr & sel_margin;
  wire wr_ctrl = reg_wr & sel_ctrl;
  wire wr_flags = reg_wr & sel_flags;

  ////////////////////////////////////////////////////////////////////////
  // detector mode and comparator path

  wire bod_on = (bod_mode != BOD_OFF);
  wire sampled_mode = (bod_mode == BOD_SAMPLED);
  // the comparator only runs when the detector does and the watch is enabled
  wire watch_on = bod_on & irq_en_q;
  // continuous modes sample every cycle, sampled mode only on the tick
  wire sample = watch_on & (sampled_mode ? bod_sample_tick : 1'b1);

  logic below_sync;
  logic trigger;

  pin_sync #(
    .RESET_VAL(1'b0)
  ) u_cmp_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin_in(cmp_below),
    .level_out(below_sync)
  );

  edge_match u_edge (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .below(below_sync),
    .sample(sample),
    .sampled_mode(sampled_mode),
    .edge_sel(edge_q),
    .trigger(trigger)
  );

  // enabling the interrupt with either-edge selected flags once in continuous modes
  wire enable_rise = wr_ctrl & reg_wdata[IRQ_EN_BIT] & ~irq_en_q;
  wire forced_set = enable_rise & bod_on & ~sampled_mode
    & (reg_wdata[EDGE_LSB+1:EDGE_LSB] == EDGE_EITHER);
  wire flag_set = bod_on & (trigger | forced_set);
  wire flag_clr = wr_flags & reg_wdata[FLAG_BIT];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    margin_d = margin_q;
    edge_d = edge_q;
    irq_en_d = irq_en_q;
    flag_d = flag_q;
    if (wr_margin) begin
      margin_d = reg_wdata[MARGIN_LSB+1:MARGIN_LSB];
    end
    if (wr_ctrl) begin
      edge_d = reg_wdata[EDGE_LSB+1:EDGE_LSB];
      irq_en_d = reg_wdata[IRQ_EN_BIT];
    end
    // a set in the clearing cycle wins, so no crossing is lost
    if (flag_set) begin
      flag_d = 1'b1;
    end else if (flag_clr) begin
      flag_d = 1'b0;
    end
  end

  always_comb begin
    rdata_d = READ_UNMAPPED;
    if (reg_rd) begin
      if (sel_margin) begin
        rdata_d = {6'h00, margin_q};
      end else if (sel_ctrl) begin
        rdata_d = {5'h00, edge_q, irq_en_q};
      end else if (sel_flags) begin
        rdata_d = {7'h00, flag_q};
      end else if (sel_status) begin
        // meaningful only while the detector runs; software screens it
        rdata_d = {7'h00, below_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      margin_q <= RST_MARGIN_CTRL[1:0];
      edge_q <= RST_IRQ_CTRL[2:1];
      irq_en_q <= RST_IRQ_CTRL[0];
      flag_q <= RST_IRQ_FLAGS[0];
      rdata_q <= READ_UNMAPPED;
    end else begin
      margin_q <= margin_d;
      edge_q <= edge_d;
      irq_en_q <= irq_en_d;
      flag_q <= flag_d;
      rdata_q <= rdata_d;
    end
  end

  // status holds the last sampled level so sampled mode reads consistently
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      below_q <= 1'b0;
    end else if (sample) begin
      below_q <= below_sync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      thresh_q <= '0;
      watch_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      // analog side decodes {level, margin}; a level change moves it too
      thresh_q <= {brownout_threshold_select, margin_q};
      watch_en_q <= watch_on;
      irq_q <= irq_en_d & flag_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign watch_threshold = thresh_q;
  assign watch_enable = watch_en_q;
  assign watch_irq = irq_q;
endmodule

// ===== logic/level_watch_pkg.sv
/*
  Package for the supply level watch register bank: register offsets,
  field positions, reset values, encodings and the bus width.
  Assumes nothing of its surroundings; imported by every design file.
*/
package level_watch_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [3:0] OFS_MARGIN_CTRL = 4'h8;
  localparam logic [3:0] OFS_IRQ_CTRL = 4'h9;
  localparam logic [3:0] OFS_IRQ_FLAGS = 4'hA;
  localparam logic [3:0] OFS_STATUS = 4'hB;

  localparam logic [7:0] RST_MARGIN_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int unsigned MARGIN_LSB = 0;
  localparam int unsigned IRQ_EN_BIT = 0;
  localparam int unsigned EDGE_LSB = 1;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned STATUS_BIT = 0;

  localparam logic [1:0] MARGIN_5PCT = 2'h0;
  localparam logic [1:0] MARGIN_15PCT = 2'h1;
  localparam logic [1:0] MARGIN_25PCT = 2'h2;

  localparam logic [1:0] EDGE_FROM_ABOVE = 2'h0;
  localparam logic [1:0] EDGE_FROM_BELOW = 2'h1;
  localparam logic [1:0] EDGE_EITHER = 2'h2;

  // brown-out operating mode codes
  localparam logic [1:0] BOD_OFF = 2'h0;
  localparam logic [1:0] BOD_ON = 2'h1;
  localparam logic [1:0] BOD_SAMPLED = 2'h2;
  localparam logic [1:0] BOD_ON_HALT = 2'h3;

  // threshold code sent to the analog side: {brown-out level, margin}
  localparam int unsigned BOD_LEVEL_W = 3;
  localparam int unsigned THRESH_W = BOD_LEVEL_W + 2;

  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;
endpackage

// ===== logic/pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for one level from a pin.
  Assumes the input is asynchronous to sys_clk; output moves only once the
  second and third stages agree.
*/
`timescale 1ns/10ps
module pin_sync
  import level_watch_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  wire agree = (s2_q == s3_q);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_out = level_q;
endmodule

// ===== logic/edge_match.sv
/*
  Crossing detector: compares the filtered below-threshold level with its
  previous value and reports which crossings match the edge selection.
  Assumes a synchronised level and a sample strobe on sys_clk.
*/
`timescale 1ns/10ps
module edge_match
  import level_watch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic below,
  input wire logic sample,
  input wire logic sampled_mode,
  input wire logic [1:0] edge_sel,
  output logic trigger
);
  logic prev_q;
  wire went_below = sample & below & ~prev_q;
  wire went_above = sample & ~below & prev_q;
  logic hit;

  // sampled mode only honours from-below selection
  always_comb begin
    hit = 1'b0;
    case (edge_sel)
      EDGE_FROM_ABOVE: hit = went_below & ~sampled_mode;
      EDGE_FROM_BELOW: hit = went_above;
      EDGE_EITHER: hit = (went_below | went_above) & ~sampled_mode;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else if (sample) begin
      prev_q <= below;
    end
  end

  assign trigger = hit;
endmodule

// ===== dv/level_watch_asserts.sv
/* Checker for the level watch register bank, bound to level_watch_regs.
   Assumes synchronous active-low reset and the package constants. */
`timescale 1ns/10ps
module level_watch_asserts
  import level_watch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [1:0] bod_mode,
  input wire logic [BOD_LEVEL_W-1:0] brownout_threshold_select,
  input wire logic bod_sample_tick,
  input wire logic cmp_below,
  input wire logic [THRESH_W-1:0] watch_threshold,
  input wire logic watch_enable,
  input wire logic watch_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic wr_flags = reg_wr && reg_addr == OFS_IRQ_FLAGS;
  ////////////////////////////////////////////////////////////////
  a_level_track: assert property ($past(resetn) |->
    watch_threshold[4:2] == $past(brownout_threshold_select)) else $error("level lost");
  a_margin_code: assert property (reg_wr && reg_addr == OFS_MARGIN_CTRL |=> ##1
    watch_threshold[1:0] == $past(reg_wdata[1:0], 2)) else $error("margin lost");
  a_enable_mode: assert property (watch_enable |-> $past(bod_mode) != BOD_OFF)
    else $error("enabled while off");
  a_irq_holds: assert property (watch_irq && !reg_wr |=> watch_irq)
    else $error("request dropped");
  a_irq_clear: assert property (wr_flags && reg_wdata[0] && bod_mode == BOD_OFF |=>
    !watch_irq) else $error("flag not cleared");
  a_no_set_off: assert property ($rose(watch_irq) |->
    $past(bod_mode) != BOD_OFF || $past(reg_wr)) else $error("flag set while off");
  a_flag_read: assert property (reg_rd && reg_addr == OFS_IRQ_FLAGS && watch_irq |=>
    reg_rdata[0]) else $error("flag reads low");
  a_rsvd_zero: assert property (reg_rd |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved bits set");
  a_hole_zero: assert property (reg_rd && reg_addr < OFS_MARGIN_CTRL |=>
    reg_rdata == READ_UNMAPPED) else $error("hole reads data");
  c_irq_rise: cover property ($rose(watch_irq));
  c_sampled: cover property (bod_mode == BOD_SAMPLED && watch_irq);
  c_clear: cover property (wr_flags && reg_wdata[0] && watch_irq);
endmodule

bind level_watch_regs level_watch_asserts u_chk (.sys_clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .bod_mode, .brownout_threshold_select, .bod_sample_tick,
  .cmp_below, .watch_threshold, .watch_enable, .watch_irq);

// ===== dv/supply_cmp_model.sv
/* Stand-in for the analog comparator: decodes {level, margin} to millivolts.
   Assumes the bench sets the supply in millivolts. */
`timescale 1ns/10ps
module supply_cmp_model
  import level_watch_pkg::*;
(
  input wire logic [THRESH_W-1:0] watch_threshold,
  input wire logic [15:0] supply_mv,
  output logic cmp_below
);
  localparam int unsigned LEVEL_MV [8] = '{1800, 2150, 2600, 2950, 3300, 3700, 4000, 4300};
  // reserved margin code has no documented value, any plain figure will do
  localparam int unsigned PCT [4] = '{5, 15, 25, 25};
  int unsigned thr_mv;
  assign thr_mv = LEVEL_MV[watch_threshold[4:2]] * (100 + PCT[watch_threshold[1:0]]) / 100;
  assign cmp_below = {16'h0000, supply_mv} < thr_mv;
endmodule

// ===== dv/level_watch_regs_tb_top.sv
/* Self-checking bench for level_watch_regs with the comparator stand-in.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module level_watch_regs_tb_top
  import level_watch_pkg::*;
;
  localparam logic [15:0] HIGH_MV = 16'h1770;
  localparam logic [15:0] LOW_MV = 16'h03E8;
  logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tick = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, e;
  logic [1:0] bod_mode = BOD_ON;
  logic [BOD_LEVEL_W-1:0] bod_level = 3'h0;
  logic [15:0] supply_mv = HIGH_MV;
  logic [7:0] lfsr = 8'h06;
  logic [DATA_W-1:0] exp_q[$];
  logic rd_p1 = 1'b0;
  wire logic [DATA_W-1:0] reg_rdata;
  wire logic [THRESH_W-1:0] watch_threshold;
  wire logic watch_enable, watch_irq, cmp_below;
  int failures = 0, compares = 0, cyc = 0;
  level_watch_regs DUT (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bod_mode, .brownout_threshold_select(bod_level), .bod_sample_tick(tick),
    .cmp_below, .watch_threshold, .watch_enable, .watch_irq);
  supply_cmp_model u_cmp (.watch_threshold, .supply_mv, .cmp_below);
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // strobes are left up so back-to-back requests never reassign in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr <= 1'b1; reg_rd <= 1'b0; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_rd <= 1'b1; reg_wr <= 1'b0; reg_addr <= a; exp_q.push_back(d);
    @(posedge sys_clk);
  endtask
  task automatic pause(input int n);
    reg_rd <= 1'b0; reg_wr <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4) == 0;
    rd_p1 <= reg_rd;
  end
  // read data stands only in the cycle after the strobe
  always @(negedge sys_clk) begin
    if (rd_p1) begin
      e = exp_q.pop_front();
      `CHK("read data", e, reg_rdata)
    end
  end
  initial begin
    for (int i = 0; i < 20000; i++) @(posedge sys_clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    pause(2);
    wr(4'h3, 8'hFF);
    for (int a = 3; a < 12; a++) rd(a[3:0], 8'h00);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      bod_level <= lfsr[7:5];
      wr(OFS_MARGIN_CTRL, lfsr);
      rd(OFS_MARGIN_CTRL, {6'h00, lfsr[1:0]});
      pause(3);
      `CHK("threshold", {lfsr[7:5], lfsr[1:0]}, watch_threshold)
    end
    wr(OFS_IRQ_CTRL, 8'hFE);
    rd(OFS_IRQ_CTRL, 8'h06);
    for (int c = 0; c < 3; c++) begin
      wr(OFS_IRQ_CTRL, {5'h00, c[1:0], 1'b1});
      pause(12);
      `CHK("enable", 1'b1, watch_enable)
      if (c == 2) rd(OFS_IRQ_FLAGS, 8'h01);
      wr(OFS_IRQ_FLAGS, 8'h01);
      supply_mv <= LOW_MV;
      pause(12);
      rd(OFS_IRQ_FLAGS, {7'h00, c != 1});
      rd(OFS_STATUS, 8'h01);
      wr(OFS_IRQ_FLAGS, 8'h00);
      rd(OFS_IRQ_FLAGS, {7'h00, c != 1});
      `CHK("irq", c != 1, watch_irq)
      wr(OFS_IRQ_FLAGS, 8'h01);
      supply_mv <= HIGH_MV;
      pause(12);
      rd(OFS_IRQ_FLAGS, {7'h00, c != 0});
      rd(OFS_STATUS, 8'h00);
      wr(OFS_IRQ_FLAGS, 8'h01);
      wr(OFS_IRQ_CTRL, 8'h00);
    end
    wr(OFS_IRQ_CTRL, 8'h05);
    bod_mode <= BOD_OFF;
    pause(12);
    supply_mv <= LOW_MV;
    pause(12);
    // status is not read while the detector is off
    rd(OFS_IRQ_FLAGS, 8'h01);
    `CHK("enable", 1'b0, watch_enable)
    wr(OFS_IRQ_FLAGS, 8'h01);
    supply_mv <= HIGH_MV;
    pause(12);
    rd(OFS_IRQ_FLAGS, 8'h00);
    bod_mode <= BOD_SAMPLED;
    wr(OFS_IRQ_CTRL, 8'h01);
    pause(12);
    supply_mv <= LOW_MV;
    pause(20);
    rd(OFS_IRQ_FLAGS, 8'h00);
    rd(OFS_STATUS, 8'h01);
    wr(OFS_IRQ_CTRL, 8'h03);
    supply_mv <= HIGH_MV;
    pause(20);
    rd(OFS_IRQ_FLAGS, 8'h01);
    // mid-run reset: everything back to reset values, first read at first edge
    resetn <= 1'b0;
    pause(3);
    resetn <= 1'b1;
    rd(OFS_IRQ_CTRL, RST_IRQ_CTRL);
    rd(OFS_IRQ_FLAGS, RST_IRQ_FLAGS);
    rd(OFS_MARGIN_CTRL, RST_MARGIN_CTRL);
    pause(2);
    `CHK("irq", 1'b0, watch_irq)
    `CHK("threshold", {bod_level, RST_MARGIN_CTRL[1:0]}, watch_threshold)
    pause(4);
    close_out();
  end
endmodule
